// file: rtl/sif_input_formatter.sv
`timescale 1ns/1ps
`include "sif_cfg.svh"
// Summary of operation
// - Start address is 16-bit byte address, 64KB
// - Fetch sample count field plus one samples
// - Append zeros up to transform length
// - Advance address by stride per sample
// - Repeat iteration count field plus one times
// - Iterations run back-to-back, no trigger
// - Each iteration start moves by iteration offset
// - Real select: 0 complex, 1 real
// - Real input gives zero imaginary part
// - Width select: 0 16-bit, 1 32-bit
// - Signed: sign extend or saturate; else unsigned
// - Conjugate negates imaginary part
// - Scale field shifts words into 24 bits
// - 16-bit pads low zeros; 32-bit drops, clips
// - One complex sample per clock cycle
// - Zero padding only with transform enabled
module sif_input_formatter
(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	output sif_pkg::sif_mem_req_type   mem_req,
	input  wire logic [127:0]          mem_rdata,
	output sif_pkg::sif_sample_type    sample_out,
	output logic                       busy
);
	// ==========================================================
	// Registers
	logic [15:0]  start_addr_reg;
	logic [11:0]  sample_cnt_reg;
	logic [15:0]  stride_reg;
	logic [11:0]  iter_cnt_reg;
	logic [15:0]  iter_ofs_reg;
	logic         real_sel_reg;
	logic         width_sel_reg;
	logic         signed_sel_reg;
	logic         conj_en_reg;
	logic [7:0]   scale_reg;
	logic         transform_function_enable_reg;
	logic [3:0]   len_log2_reg;
	logic         ack_reg;
	logic [31:0]  rdata_reg;
	sif_pkg::sif_state_type state_reg;
	logic [11:0]  samp_idx_reg;
	logic [11:0]  iter_idx_reg;
	logic [15:0]  iter_base_reg;
	logic [15:0]  addr_reg;
	logic         pend_reg;
	logic         pend_last_reg;
	logic         pend_pad_reg;
	logic [3:0]   pend_lane_reg;

	// ==========================================================
	// Avalon slave: one wait cycle, then ack
	// The write lands on the edge that shows waitrequest low, not before
	wire         access     = (avs_read | avs_write) & ~ack_reg;
	wire         wr_go      = avs_write & ack_reg;
	wire         hit_ctl    = avs_address == `SIF_OFS_CONTROL;
	wire         hit_start  = avs_address == `SIF_OFS_START_ADDR;
	wire         hit_cnt    = avs_address == `SIF_OFS_SAMPLE_CNT;
	wire         hit_stride = avs_address == `SIF_OFS_STRIDE;
	wire         hit_icnt   = avs_address == `SIF_OFS_ITER_CNT;
	wire         hit_iofs   = avs_address == `SIF_OFS_ITER_OFS;
	wire         hit_fmt    = avs_address == `SIF_OFS_FORMAT;
	wire         hit_scale  = avs_address == `SIF_OFS_SCALE;
	wire         hit_status = avs_address == `SIF_OFS_STATUS;
	wire         hit_pos    = avs_address == `SIF_OFS_POSITION;
	wire         start_go   = wr_go & hit_ctl & avs_writedata[`SIF_CTL_START_BIT];

	logic [31:0] rd_mux;

	// ==========================================================
	// Read decode; unmapped words read as zero
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_ctl)
			rd_mux = {24'h0, len_log2_reg, 2'h0, transform_function_enable_reg, 1'h0};
		else if (hit_start)
			rd_mux = {16'h0, start_addr_reg};
		else if (hit_cnt)
			rd_mux = {20'h0, sample_cnt_reg};
		else if (hit_stride)
			rd_mux = {16'h0, stride_reg};
		else if (hit_icnt)
			rd_mux = {20'h0, iter_cnt_reg};
		else if (hit_iofs)
			rd_mux = {16'h0, iter_ofs_reg};
		else if (hit_fmt)
			rd_mux = {28'h0, conj_en_reg, signed_sel_reg, width_sel_reg, real_sel_reg};
		else if (hit_scale)
			rd_mux = {24'h0, scale_reg};
		else if (hit_status)
			rd_mux = {31'h0, busy};
		else if (hit_pos)
			rd_mux = {4'h0, iter_idx_reg, 4'h0, samp_idx_reg};
	end

	// Readdata is zero unless read was high in the cycle before
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
			rdata_reg       <= 32'h0;
		end
		else
		begin
			ack_reg         <= access;
			avs_waitrequest <= ~access;
			rdata_reg       <= avs_read ? rd_mux : 32'h0;
		end
	end
	assign avs_readdata = rdata_reg;

	// ==========================================================
	// Configuration is locked while busy so a run sees one parameter set
	// Writes to unmapped words fall through and are dropped
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			start_addr_reg <= 16'h0;
			sample_cnt_reg <= 12'h0;
			stride_reg     <= 16'h0;
			iter_cnt_reg   <= 12'h0;
			iter_ofs_reg   <= 16'h0;
			real_sel_reg   <= 1'b0;
			width_sel_reg  <= 1'b0;
			signed_sel_reg <= 1'b0;
			conj_en_reg    <= 1'b0;
			scale_reg      <= 8'h0;
			transform_function_enable_reg     <= 1'b0;
			len_log2_reg   <= 4'h0;
		end
		else if (wr_go && !busy)
		begin
			if (hit_ctl)
			begin
				transform_function_enable_reg   <= avs_writedata[`SIF_CTL_TRANSFORM_FUNCTION_ENABLE_BIT];
				len_log2_reg <= avs_writedata[`SIF_CTL_LEN_MSB:`SIF_CTL_LEN_LSB];
			end
			else if (avs_address == `SIF_OFS_START_ADDR)
				start_addr_reg <= avs_writedata[15:0];
			else if (avs_address == `SIF_OFS_SAMPLE_CNT)
				sample_cnt_reg <= avs_writedata[11:0];
			else if (avs_address == `SIF_OFS_STRIDE)
				stride_reg <= avs_writedata[15:0];
			else if (avs_address == `SIF_OFS_ITER_CNT)
				iter_cnt_reg <= avs_writedata[11:0];
			else if (avs_address == `SIF_OFS_ITER_OFS)
				iter_ofs_reg <= avs_writedata[15:0];
			else if (avs_address == `SIF_OFS_FORMAT)
			begin
				real_sel_reg   <= avs_writedata[`SIF_FMT_REAL_BIT];
				width_sel_reg  <= avs_writedata[`SIF_FMT_WIDTH_BIT];
				signed_sel_reg <= avs_writedata[`SIF_FMT_SIGNED_BIT];
				conj_en_reg    <= avs_writedata[`SIF_FMT_CONJ_BIT];
			end
			else if (avs_address == `SIF_OFS_SCALE)
				scale_reg <= avs_writedata[7:0];
		end
	end

	// ==========================================================
	// Sequencer
	// Count fields hold the number minus one
	wire [12:0] fetch_total = {1'b0, sample_cnt_reg} + 13'h1;
	// Lengths of 2^13 and up wrap to zero here; keep the length field small
	wire [12:0] len_total   = 13'(13'h1 << len_log2_reg);
	wire        do_pad      = transform_function_enable_reg && (fetch_total < len_total);
	// Pad slots reuse the sample index, so padding needs no counter
	wire [12:0] samp_next13 = {1'b0, samp_idx_reg} + 13'h1;
	wire        last_fetch  = samp_idx_reg == sample_cnt_reg;
	wire        last_pad    = samp_next13 == len_total;
	wire        last_iter   = iter_idx_reg == iter_cnt_reg;
	// Address walks incrementally: start + i*iter_ofs + s*stride, mod 64K
	wire [15:0] next_base   = iter_base_reg + iter_ofs_reg;
	wire        fetch_end   = state_reg == sif_pkg::SIF_FETCH && last_fetch && !do_pad;
	wire        pad_end     = state_reg == sif_pkg::SIF_PAD && last_pad;
	wire        end_iter    = fetch_end || pad_end;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg     <= sif_pkg::SIF_IDLE;
			samp_idx_reg  <= 12'h0;
			iter_idx_reg  <= 12'h0;
			iter_base_reg <= 16'h0;
			addr_reg      <= 16'h0;
		end
		else
		begin
			case (state_reg)
				sif_pkg::SIF_IDLE:
				begin
					// Index and base restart for each run
					if (start_go)
					begin
						state_reg     <= sif_pkg::SIF_FETCH;
						samp_idx_reg  <= 12'h0;
						iter_idx_reg  <= 12'h0;
						iter_base_reg <= start_addr_reg;
						addr_reg      <= start_addr_reg;
					end
				end
				sif_pkg::SIF_FETCH:
				begin
					if (!last_fetch)
					begin
						samp_idx_reg <= samp_idx_reg + 12'h1;
						// Sum wraps at 64K, as the address space does
						addr_reg     <= addr_reg + stride_reg;
					end
					else if (do_pad)
					begin
						state_reg    <= sif_pkg::SIF_PAD;
						samp_idx_reg <= samp_idx_reg + 12'h1;
					end
				end
				sif_pkg::SIF_PAD:
				begin
					if (!last_pad)
						samp_idx_reg <= samp_idx_reg + 12'h1;
				end
				default:
					state_reg <= sif_pkg::SIF_IDLE;
			endcase
			if (end_iter)
			begin
				samp_idx_reg <= 12'h0;
				// Last iteration drops back to idle
				if (last_iter)
					state_reg <= sif_pkg::SIF_IDLE;
				else
				begin
					// Straight into the next iteration, no trigger
					state_reg     <= sif_pkg::SIF_FETCH;
					iter_idx_reg  <= iter_idx_reg + 12'h1;
					iter_base_reg <= next_base;
					addr_reg      <= next_base;
				end
			end
		end
	end
	wire busy_next = state_reg != sif_pkg::SIF_IDLE;

	// ==========================================================
	// Memory request; read data arrives one cycle later
	// Flags travel with the request so they meet the data it returns
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			mem_req       <= '0;
			pend_reg      <= 1'b0;
			pend_last_reg <= 1'b0;
			pend_pad_reg  <= 1'b0;
			pend_lane_reg <= 4'h0;
			busy          <= 1'b0;
		end
		else
		begin
			mem_req.rd    <= state_reg == sif_pkg::SIF_FETCH;
			mem_req.addr  <= addr_reg;
			pend_reg      <= busy_next;
			pend_pad_reg  <= state_reg == sif_pkg::SIF_PAD;
			pend_last_reg <= end_iter;
			pend_lane_reg <= addr_reg[3:0];
			busy          <= busy_next | pend_reg;
		end
	end

	// ==========================================================
	// Formatting, two cycles after the address
	logic         d_valid_reg;
	logic         d_last_reg;
	logic         d_pad_reg;
	logic [3:0]   d_lane_reg;
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			d_valid_reg <= 1'b0;
			d_last_reg  <= 1'b0;
			d_pad_reg   <= 1'b0;
			d_lane_reg  <= 4'h0;
		end
		else
		begin
			d_valid_reg <= pend_reg;
			d_last_reg  <= pend_last_reg;
			d_pad_reg   <= pend_pad_reg;
			d_lane_reg  <= pend_lane_reg;
		end
	end

	// ==========================================================
	// Conversion
	// Row is shifted so the sample sits at bit 0; no row straddling
	wire [127:0] row  = mem_rdata >> {d_lane_reg, 3'h0};
	wire [31:0]  re32 = width_sel_reg ? row[31:0] : {16'h0, row[15:0]};
	wire [31:0]  im32 = width_sel_reg ? row[63:32] : {16'h0, row[31:16]};
	wire         scale_over = scale_reg > 8'h8;
	wire [3:0]   sc   = scale_over ? 4'h8 : scale_reg[3:0];

	// Saturation works on a wide copy, so no shift can wrap
	function automatic logic [23:0] sif_conv(input logic [31:0] w, input logic wide,
		input logic sgn, input logic [3:0] s);
		logic signed [47:0] x;
		logic signed [47:0] hi;
		logic signed [47:0] lo;
		x  = 48'sh0;
		hi = 48'sh0;
		lo = 48'sh0;
		// 16-bit: place at top of 24 then shift right by scale
		if (!wide)
		begin
			x = sgn ? {{32{w[15]}}, w[15:0]} : {32'h0, w[15:0]};
			x = x <<< (4'h8 - s);
		end
		else
		begin
			x = sgn ? {{16{w[31]}}, w[31:0]} : {16'h0, w[31:0]};
			x = x >>> s;
		end
		hi = sgn ? 48'sh7FFFFF : 48'shFFFFFF;
		lo = sgn ? -48'sh800000 : 48'sh0;
		if (x > hi)
			x = hi;
		else if (x < lo)
			x = lo;
		return x[23:0];
	endfunction

	// ==========================================================
	// Output stage
	wire [23:0] re_c = sif_conv(re32, width_sel_reg, signed_sel_reg, sc);
	wire [23:0] im_r = real_sel_reg ? 24'h0 : sif_conv(im32, width_sel_reg, signed_sel_reg, sc);
	// Conjugate is ignored for real input
	wire [23:0] im_c = (conj_en_reg && !real_sel_reg) ? 24'(-im_r) : im_r;
	// Pad slots and idle cycles force zero so stale rows never leak out
	wire        zero_out = d_pad_reg || !d_valid_reg;
	wire [23:0] re_next  = zero_out ? 24'h0 : re_c;
	wire [23:0] im_next  = zero_out ? 24'h0 : im_c;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			sample_out <= '0;
		else
		begin
			sample_out.valid <= d_valid_reg;
			sample_out.last  <= d_last_reg;
			sample_out.re    <= re_next;
			sample_out.im    <= im_next;
		end
	end
endmodule // sif_input_formatter

// file: rtl/sif_cfg.svh
`ifndef SIF_CFG_SVH
`define SIF_CFG_SVH
// Register word offsets (one address per 32-bit register)
`define SIF_OFS_CONTROL     4'h0
`define SIF_OFS_START_ADDR  4'h1
`define SIF_OFS_SAMPLE_CNT  4'h2
`define SIF_OFS_STRIDE      4'h3
`define SIF_OFS_ITER_CNT    4'h4
`define SIF_OFS_ITER_OFS    4'h5
`define SIF_OFS_FORMAT      4'h6
`define SIF_OFS_SCALE       4'h7
`define SIF_OFS_STATUS      4'h8
`define SIF_OFS_POSITION    4'h9
// Control register bits
`define SIF_CTL_START_BIT   0
`define SIF_CTL_TRANSFORM_FUNCTION_ENABLE_BIT  1
`define SIF_CTL_LEN_LSB     4
`define SIF_CTL_LEN_MSB     7
// Format register bits
`define SIF_FMT_REAL_BIT    0
`define SIF_FMT_WIDTH_BIT   1
`define SIF_FMT_SIGNED_BIT  2
`define SIF_FMT_CONJ_BIT    3
// Sample conversion
`define SIF_SAMPLE_WIDTH    24
`define SIF_SCALE_MAX       8
`define SIF_MEM_ROW_BYTES   16
`endif

// file: rtl/sif_pkg.sv
package sif_pkg;
	typedef enum logic [1:0] {
		SIF_IDLE,
		SIF_FETCH,
		SIF_PAD
	} sif_state_type;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [23:0] re;
		logic [23:0] im;
	} sif_sample_type;

	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} sif_mem_req_type;
endpackage

// file: testbench/sif_chk.sv
`timescale 1ns/1ps
`include "sif_cfg.svh"
// ==========
// Port checker
module sif_chk
(
	input wire logic                     core_clk,
	input wire logic                     reset,
	input wire logic [3:0]               avs_address,
	input wire logic                     avs_read,
	input wire logic                     avs_write,
	input wire logic [31:0]              avs_writedata,
	input wire logic [31:0]              avs_readdata,
	input wire logic                     avs_waitrequest,
	input wire sif_pkg::sif_mem_req_type mem_req,
	input wire sif_pkg::sif_sample_type  sample_out,
	input wire logic                     busy
);
	logic [15:0] start_reg;
	logic        real_reg;
	// Writes during a run are refused, so only idle writes count
	wire         cfg_wr = avs_write && !avs_waitrequest && !busy;
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			start_reg <= 16'h0;
			real_reg  <= 1'b0;
		end
		else if (cfg_wr && avs_address == `SIF_OFS_START_ADDR)
			start_reg <= avs_writedata[15:0];
		else if (cfg_wr && avs_address == `SIF_OFS_FORMAT)
			real_reg <= avs_writedata[`SIF_FMT_REAL_BIT];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("Wait pulse too long");
	chk_wait_answer: assert property ($rose(avs_read || avs_write) |-> ##1 !avs_waitrequest)
		else $error("Bus answer late");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h9
		|-> avs_readdata == 32'h0) else $error("Unmapped read not zero");
	chk_first_addr: assert property ($rose(busy) |-> ##[0:2]
		(mem_req.rd && mem_req.addr == start_reg)) else $error("Bad first address");
	chk_real_imag: assert property (sample_out.valid && real_reg |-> sample_out.im == 24'h0)
		else $error("Real sample has imaginary part");
	chk_stream_gapless: assert property (sample_out.valid && !sample_out.last |=> sample_out.valid)
		else $error("Gap inside iteration");
	chk_fetch_latency: assert property ($rose(mem_req.rd) |-> ##2 sample_out.valid)
		else $error("Sample latency wrong");
	chk_idle_quiet: assert property (!busy && !$past(busy) |-> !mem_req.rd && !sample_out.valid)
		else $error("Activity while idle");
	cover property (sample_out.valid && sample_out.last);
	cover property ($rose(mem_req.rd));
	cover property (avs_write && !avs_waitrequest);
endmodule // sif_chk

bind sif_input_formatter sif_chk u_chk (.core_clk(core_clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .sample_out(sample_out), .busy(busy));

// file: testbench/sif_mem_model.sv
`timescale 1ns/1ps
// ==========
// Local sample memory
module sif_mem_model
(
	input wire logic                     core_clk,
	input wire sif_pkg::sif_mem_req_type mem_req,
	output logic [127:0]                 mem_rdata
);
	// Contents follow the byte address, so no storage is needed
	function automatic logic [7:0] mbyte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	logic [127:0] row;
	always_comb
		for (int i = 0; i < 16; i++)
			row[i*8 +: 8] = mbyte({mem_req.addr[15:4], 4'h0} + 16'(i));
	// Idle output toggles so stale rows never look valid
	initial mem_rdata = 128'h0;
	always @(posedge core_clk)
		mem_rdata <= mem_req.rd ? row : ~mem_rdata;
endmodule // sif_mem_model

// file: testbench/test_sif_input_formatter.sv
`timescale 1ns/1ps
`include "sif_cfg.svh"
// ==========
// Bench top
module test_sif_input_formatter;
	logic                     core_clk;
	logic                     reset;
	logic [3:0]               avs_address;
	logic                     avs_read;
	logic                     avs_write;
	logic [31:0]              avs_writedata;
	logic [31:0]              avs_readdata;
	logic                     avs_waitrequest;
	sif_pkg::sif_mem_req_type mem_req;
	logic [127:0]             mem_rdata;
	sif_pkg::sif_sample_type  sample_out;
	logic                     busy;
	int                       num_errors;
	int                       comparisons;
	logic [48:0]              seen_q[$];

	sif_input_formatter DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .sample_out(sample_out), .busy(busy));
	sif_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
		if (sample_out.valid === 1'b1)
			seen_q.push_back({sample_out.last, sample_out.re, sample_out.im});

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (avs_waitrequest !== 1'b0)
		begin
			num_errors++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	function automatic logic [7:0] mb(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	function automatic logic [31:0] word(input logic [15:0] a, input logic w32);
		return w32 ? {mb(a + 16'h3), mb(a + 16'h2), mb(a + 16'h1), mb(a)}
			: {16'h0, mb(a + 16'h1), mb(a)};
	endfunction
	function automatic logic [23:0] conv(input logic [31:0] w, input logic w32,
		input logic sgn, input int s);
		longint v;
		v = w32 ? (sgn ? longint'($signed(w)) : longint'(w))
			: (sgn ? longint'($signed(w[15:0])) : longint'(w[15:0]));
		v = w32 ? v >>> s : v <<< (8 - s);
		if (sgn && v > 64'sh7FFFFF) v = 64'sh7FFFFF;
		if (sgn && v < -64'sh800000) v = -64'sh800000;
		if (!sgn && v > 64'shFFFFFF) v = 64'shFFFFFF;
		return v[23:0];
	endfunction

	task automatic run(input logic [15:0] st, str, io, input logic [11:0] cnt, ic,
		input logic [3:0] fmt, input logic [7:0] sc, input logic fen, input logic [3:0] len);
		logic [48:0] exp_q[$];
		logic [15:0] a;
		logic [23:0] im;
		logic [31:0] q;
		int n, pad, k;
		k = (sc > 8) ? 8 : int'(sc);
		pad = (fen && cnt + 1 < (1 << len)) ? (1 << len) - cnt - 1 : 0;
		wr(`SIF_OFS_START_ADDR, {16'h0, st});
		wr(`SIF_OFS_SAMPLE_CNT, {20'h0, cnt});
		wr(`SIF_OFS_STRIDE, {16'h0, str});
		wr(`SIF_OFS_ITER_CNT, {20'h0, ic});
		wr(`SIF_OFS_ITER_OFS, {16'h0, io});
		wr(`SIF_OFS_FORMAT, {28'h0, fmt});
		wr(`SIF_OFS_SCALE, {24'h0, sc});
		seen_q.delete();
		wr(`SIF_OFS_CONTROL, {24'h0, len, 2'b00, fen, 1'b1});
		// Lands while busy, so it must be refused
		wr(`SIF_OFS_STRIDE, {16'h0, ~str});
		bus(1'b0, `SIF_OFS_STATUS, 32'h0, q);
		check(q[0], 1'b1);
		for (int i = 0; i <= ic; i++)
		begin
			for (int s = 0; s <= cnt; s++)
			begin
				a = 16'(int'(st) + i * int'(io) + s * int'(str));
				im = fmt[0] ? 24'h0 : conv(word(a + (fmt[1] ? 16'h4 : 16'h2), fmt[1]), fmt[1], fmt[2], k);
				if (fmt[3] && !fmt[0]) im = -im;
				exp_q.push_back({pad == 0 && s == cnt, conv(word(a, fmt[1]), fmt[1], fmt[2], k), im});
			end
			for (int p = 1; p <= pad; p++)
				exp_q.push_back({p == pad, 48'h0});
		end
		n = 0;
		while (busy !== 1'b0 && n < 5000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (busy !== 1'b0)
		begin
			num_errors++;
			complete_run();
		end
		repeat (4) @(posedge core_clk);
		check(seen_q.size(), exp_q.size());
		foreach (exp_q[j])
			check(seen_q[j], exp_q[j]);
		bus(1'b0, `SIF_OFS_STRIDE, 32'h0, q);
		check(q[15:0], str);
		$display("Run test done at %0t", $time);
	endtask

	initial
	begin
		logic [31:0] q;
		logic [31:0] mask [7] = '{32'hFFFF, 32'hFFF, 32'hFFFF, 32'hFFF, 32'hFFFF, 32'hF, 32'hFF};
		num_errors    = 0;
		comparisons   = 0;
		reset         = 1'b1;
		avs_address   = 4'h0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		for (int k = 0; k <= 10; k++)
		begin
			bus(1'b0, 4'(k), 32'h0, q);
			check(q, 32'h0);
		end
		for (int k = 1; k <= 8; k++)
		begin
			wr(k == 8 ? 4'hB : 4'(k), 32'hFFFFFFFF);
			bus(1'b0, k == 8 ? 4'hB : 4'(k), 32'h0, q);
			check(q, k == 8 ? 32'h0 : mask[k - 1]);
		end
		$display("Register test done");
		// Source rows never straddle, stride and offset stay small
		run(16'h0000, 16'h4, 16'h40, 12'h4, 12'h1, 4'h4, 8'h3, 1'b1, 4'h3);
		run(16'hFFF8, 16'h8, 16'h0, 12'h2, 12'h0, 4'h3, 8'h8, 1'b0, 4'h3);
		run(16'h0100, 16'h10, 16'h8, 12'h3, 12'h2, 4'hE, 8'h2, 1'b1, 4'h2);
		run(16'h2002, 16'h10, 16'h0, 12'h5, 12'h0, 4'h0, 8'hC, 1'b1, 4'h4);
		complete_run();
	end
endmodule // test_sif_input_formatter
